// [core/assfc_pkg.sv]
// assfc_pkg: register map, reset values, codes and carrier types for the
// two-channel sample timing, scaling, filtering and logical processing.
// assumes one 20 MHz clock and a same-clock configuration write port.
// Behaviour
// - sample period word is unsigned 16.16 microseconds: value = us * 65536.
// - physical period resolves to whole microseconds; fraction corrects average.
// - logical period is divider (1..10, default 2) times physical period.
// - signed microsecond offset -32,768..32,767 shifts the cycle; default 0.
// - per-channel signed 16.16 gain; 65535 acts as unity and default.
// - per-channel signed 16.16 offset, 65536 means one; default 0.
// - every conversion is scaled then filtered per channel independently.
// - second-order filter uses three forward, two feedback signed coefficients.
// - per-channel low-pass cutoff in hertz 0..65535, default 1000.
// - mode bits 0..2 select voltage 000 or current 111; current clamps negative results to 0.
// - mode bits 8..10 select off/raw/IIR/LP1/LP2; reset value 256.
// - six logical channels decode codes 0,256,257,512,513,768,1024.
// - logical channels 1,2 default to 256; channels 3..6 default off.
// - physical value display is the reset setting of logical channels 1 and 2 only.
// - each logical channel has two source selectors and two parameters.
// - selector 0,1 pick physical channels; 8 upward pick logical channels.
// - logical parameters are unsigned 32-bit, 65536 meaning one.
// - sixteen-entry history per physical channel, entry 1 newest.
package assfc_pkg;

  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned US_PER_S   = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
  localparam int unsigned US_DIV_W   = $clog2(CYC_PER_US);
  localparam int unsigned N_PHYS     = 2;
  localparam int unsigned N_LOGIC    = 6;
  localparam int unsigned HIST_DEPTH = 16;

  // register numbers as printed; channel blocks repeat every stride
  localparam logic [15:0] ADDR_SAMPLE_PERIOD = 16'h3c04;
  localparam logic [15:0] ADDR_CYCLE_SHIFT   = 16'h3c0a;
  localparam logic [15:0] ADDR_LOGIC_DIV     = 16'h3c0e;
  localparam logic [15:0] CHAN_STRIDE        = 16'h0100;
  localparam logic [15:0] ADDR_CHAN_PROC     = 16'h2002;
  localparam logic [15:0] ADDR_CHAN_LOWPASS  = 16'h2006;
  localparam logic [15:0] ADDR_CHAN_MULT     = 16'h200c;
  localparam logic [15:0] ADDR_CHAN_ADD      = 16'h2014;
  localparam logic [15:0] ADDR_CHAN_FF0      = 16'h201c;
  localparam logic [15:0] ADDR_CHAN_FF1      = 16'h2024;
  localparam logic [15:0] ADDR_CHAN_FF2      = 16'h202c;
  localparam logic [15:0] ADDR_CHAN_FB1      = 16'h2034;
  localparam logic [15:0] ADDR_CHAN_FB2      = 16'h203c;
  localparam logic [15:0] LOGIC_STRIDE       = 16'h0100;
  localparam logic [15:0] ADDR_LOGIC_CODE    = 16'h2802;
  localparam logic [15:0] ADDR_LOGIC_IN_A    = 16'h2805;
  localparam logic [15:0] ADDR_LOGIC_IN_B    = 16'h2807;
  localparam logic [15:0] ADDR_LOGIC_PAR0    = 16'h2814;
  localparam logic [15:0] ADDR_LOGIC_PAR1    = 16'h281c;

  // reset values
  localparam logic [31:0] RST_SAMPLE_PERIOD = 32'h0064_0000;
  localparam logic [15:0] RST_LOGIC_DIV     = 16'h0002;
  localparam logic [15:0] RST_CYCLE_SHIFT   = 16'h0000;
  localparam logic [31:0] RST_SCALE_MULT    = 32'h0000_ffff;
  localparam logic [15:0] RST_LOWPASS_HZ    = 16'h03e8;
  localparam logic [15:0] RST_PROC_SELECT   = 16'h0100;
  localparam logic [31:0] UNITY_Q16         = 32'h0001_0000;
  localparam logic [15:0] DIV_MAX           = 16'h000a;

  // channel mode fields and codes
  localparam int unsigned CONN_LSB = 0;
  localparam int unsigned PROC_LSB = 8;
  localparam logic [2:0] CONN_CURRENT = 3'h7;
  localparam logic [2:0] PROC_OFF  = 3'h0;
  localparam logic [2:0] PROC_RAW  = 3'h1;
  localparam logic [2:0] PROC_IIR  = 3'h2;
  localparam logic [2:0] PROC_LP1  = 3'h3;
  localparam logic [2:0] PROC_LP2  = 3'h4;

  // logical function codes and source selectors
  localparam logic [15:0] FN_OFF  = 16'h0000;
  localparam logic [15:0] FN_ADD  = 16'h0100;
  localparam logic [15:0] FN_IADD = 16'h0101;
  localparam logic [15:0] FN_MUL  = 16'h0200;
  localparam logic [15:0] FN_IMUL = 16'h0201;
  localparam logic [15:0] FN_CMP  = 16'h0300;
  localparam logic [15:0] FN_HYST = 16'h0400;
  localparam logic [7:0]  SRC_LOGIC_BASE = 8'h08;
  localparam int unsigned N_DISPLAY = 2;

  // low-pass weight ~ 2*pi*fc*T in q16, T in whole us: * 422 / 1024
  localparam logic [15:0] LP_K_NUM   = 16'h01a6;
  localparam int unsigned LP_K_SHIFT = 10;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [31:0] data;
  } assfc_wr_t;

  typedef struct packed {
    logic [15:0] proc_select;
    logic [15:0] lowpass_hz;
    logic [31:0] scale_mult;
    logic [31:0] scale_add;
    logic [31:0] ff_coef0;
    logic [31:0] ff_coef1;
    logic [31:0] ff_coef2;
    logic [31:0] fb_coef1;
    logic [31:0] fb_coef2;
  } assfc_chan_cfg_t;

  typedef struct packed {
    logic [15:0] function_code;
    logic [7:0]  input_a;
    logic [7:0]  input_b;
    logic [31:0] param0;
    logic [31:0] param1;
  } assfc_logic_cfg_t;

endpackage

// [core/assfc_core.sv]
// assfc_core: sample timer, per-channel scaling and filtering, history
// and six logical channels, configured through a write-only register port.
// assumes the converter answers each sample_tick with conv_valid on clk_sys.

module assfc_core
  import assfc_pkg::*;
#(
  parameter int unsigned HIST_LEN = HIST_DEPTH
) (
  input  logic                                     clk_sys,
  input  logic                                     reset_n,
  input  assfc_wr_t                                cfg_wr,
  input  logic                                     conv_valid,
  input  logic [N_PHYS-1:0][15:0]                  conv_data,
  output logic                                     sample_tick,
  output logic                                     logic_tick,
  output logic                                     phys_valid,
  output logic                                     logic_valid,
  output wire  [N_PHYS-1:0][15:0]                  phys_value,
  output wire  [N_PHYS-1:0][HIST_LEN-1:0][15:0]    phys_hist,
  output wire  [N_LOGIC-1:0][31:0]                 logic_value
);

  function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_0000_7fff) begin
      return 16'sh7fff;
    end else if (v < -64'sh0000_0000_0000_8000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction

  function automatic logic signed [31:0] sat32(input logic signed [65:0] v);
    if (v > 66'sh0_0000_0000_7fff_ffff) begin
      return 32'sh7fff_ffff;
    end else if (v < -66'sh0_0000_0000_8000_0000) begin
      return -32'sh8000_0000;
    end
    return v[31:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // global configuration and sample timer

  logic [31:0]         sample_period_fixed, next_sample_period_fixed;
  logic [15:0]         logic_period_divider, next_logic_period_divider;
  logic [15:0]         cycle_shift_us, next_cycle_shift_us;
  logic [US_DIV_W-1:0] us_div, next_us_div;
  logic signed [17:0]  period_left, next_period_left;
  logic [15:0]         frac_acc, next_frac_acc;
  logic signed [15:0]  shift_pend, next_shift_pend;
  logic [15:0]         logic_cnt, next_logic_cnt;
  logic                next_sample_tick, next_logic_tick, next_logic_valid;
  logic                us_tick;
  logic [16:0]         frac_sum;
  logic signed [17:0]  period_len;
  logic [15:0]         div_eff;

  // whole-microsecond period; fractional carry lengthens a period by 1 us
  always_comb begin
    next_sample_period_fixed  = sample_period_fixed;
    next_logic_period_divider = logic_period_divider;
    next_cycle_shift_us       = cycle_shift_us;
    next_us_div               = us_div + US_DIV_W'(1);
    next_period_left          = period_left;
    next_frac_acc             = frac_acc;
    next_shift_pend           = shift_pend;
    next_logic_cnt            = logic_cnt;
    next_sample_tick          = 1'b0;
    next_logic_tick           = 1'b0;
    next_logic_valid          = logic_tick;
    us_tick  = (us_div == US_DIV_W'(CYC_PER_US - 1));
    frac_sum = {1'b0, frac_acc} + {1'b0, sample_period_fixed[15:0]};
    period_len = $signed({2'b00, sample_period_fixed[31:16]})
               + $signed({17'h0_0000, frac_sum[16]})
               + $signed({{2{shift_pend[15]}}, shift_pend});
    if (period_len < 18'sh0_0001) begin
      period_len = 18'sh0_0001;
    end
    // out-of-range divider is clamped rather than stopping logic ticks
    if (logic_period_divider == 16'h0000) begin
      div_eff = 16'h0001;
    end else if (logic_period_divider > DIV_MAX) begin
      div_eff = DIV_MAX;
    end else begin
      div_eff = logic_period_divider;
    end
    if (us_tick) begin
      next_us_div = '0;
      if (period_left <= 18'sh0_0001) begin
        next_sample_tick = 1'b1;
        next_period_left = period_len;
        next_frac_acc    = frac_sum[15:0];
        next_shift_pend  = 16'sh0000;
        if (logic_cnt + 16'h0001 >= div_eff) begin
          next_logic_cnt  = 16'h0000;
          next_logic_tick = 1'b1;
        end else begin
          next_logic_cnt = logic_cnt + 16'h0001;
        end
      end else begin
        next_period_left = period_left - 18'sh0_0001;
      end
    end
    // register writes; a new shift overrides one just consumed
    if (cfg_wr.en) begin
      unique case (cfg_wr.addr)
        ADDR_SAMPLE_PERIOD: next_sample_period_fixed = cfg_wr.data;
        ADDR_LOGIC_DIV:     next_logic_period_divider = cfg_wr.data[15:0];
        ADDR_CYCLE_SHIFT: begin
          next_cycle_shift_us = cfg_wr.data[15:0];
          next_shift_pend     = $signed(cfg_wr.data[15:0]);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sample_period_fixed  <= RST_SAMPLE_PERIOD;
      logic_period_divider <= RST_LOGIC_DIV;
      cycle_shift_us       <= RST_CYCLE_SHIFT;
      us_div               <= '0;
      period_left          <= 18'sh0_0001;
      frac_acc             <= 16'h0000;
      shift_pend           <= 16'sh0000;
      logic_cnt            <= 16'h0000;
      sample_tick          <= 1'b0;
      logic_tick           <= 1'b0;
      logic_valid          <= 1'b0;
    end else begin
      sample_period_fixed  <= next_sample_period_fixed;
      logic_period_divider <= next_logic_period_divider;
      cycle_shift_us       <= next_cycle_shift_us;
      us_div               <= next_us_div;
      period_left          <= next_period_left;
      frac_acc             <= next_frac_acc;
      shift_pend           <= next_shift_pend;
      logic_cnt            <= next_logic_cnt;
      sample_tick          <= next_sample_tick;
      logic_tick           <= next_logic_tick;
      logic_valid          <= next_logic_valid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phys_valid <= 1'b0;
    end else begin
      phys_valid <= conv_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // physical channels: scale, filter, saturate, history

  for (genvar g = 0; g < N_PHYS; g++) begin : g_phys
    assfc_chan_cfg_t           cfg, next_cfg;
    logic signed [15:0]        x1, x2, y1, y2;
    logic signed [15:0]        next_x1, next_x2, next_y1, next_y2;
    logic signed [31:0]        lp1, lp2, next_lp1, next_lp2;
    logic signed [15:0]        value, next_value;
    logic [HIST_LEN-1:0][15:0] hist, next_hist;
    logic [15:0]               off;
    logic                      clr;
    logic signed [47:0]        prod;
    logic signed [15:0]        s;
    logic signed [63:0]        acc, e1, e2;
    logic [47:0]               lp_w;
    logic signed [17:0]        alpha;
    logic [2:0]                proc_mode;

    assign phys_value[g] = value;
    assign phys_hist[g]  = hist;

    always_comb begin
      next_cfg   = cfg;
      next_x1    = x1;
      next_x2    = x2;
      next_y1    = y1;
      next_y2    = y2;
      next_lp1   = lp1;
      next_lp2   = lp2;
      next_value = value;
      next_hist  = hist;
      clr        = 1'b0;
      proc_mode  = cfg.proc_select[PROC_LSB +: 3];
      off        = cfg_wr.addr - 16'(CHAN_STRIDE * g);
      // rounding makes a gain of 65535 return every input but -32768 unchanged
      prod = 48'($signed(conv_data[g])) * 48'($signed(cfg.scale_mult));
      s = sat16(64'((prod + 48'($signed(cfg.scale_add))
                    + 48'sh0000_0000_8000) >>> 16));
      if (cfg.proc_select[CONN_LSB +: 3] == CONN_CURRENT && s < 0) begin
        s = 16'sh0000;                            // current input is unipolar
      end
      lp_w = 48'(cfg.lowpass_hz) * 48'(sample_period_fixed[31:16])
           * 48'(LP_K_NUM);
      if ((lp_w >> LP_K_SHIFT) > 48'(UNITY_Q16)) begin
        alpha = $signed({1'b0, UNITY_Q16[16:0]});
      end else begin
        alpha = $signed({1'b0, 17'(lp_w >> LP_K_SHIFT)});
      end
      acc = 64'($signed(cfg.ff_coef0)) * 64'(s)
          + 64'($signed(cfg.ff_coef1)) * 64'(x1)
          + 64'($signed(cfg.ff_coef2)) * 64'(x2)
          - 64'($signed(cfg.fb_coef1)) * 64'(y1)
          - 64'($signed(cfg.fb_coef2)) * 64'(y2);
      e1 = 64'($signed({s, 16'h0000})) - 64'(lp1);
      e2 = 64'(lp1) - 64'(lp2);
      if (conv_valid) begin
        unique case (proc_mode)
          PROC_RAW: next_value = s;
          PROC_IIR: begin
            next_value = sat16(acc >>> 16);
            next_x1 = s;
            next_x2 = x1;
            next_y1 = next_value;
            next_y2 = y1;
          end
          PROC_LP1: begin
            next_lp1   = 32'(64'(lp1) + ((64'(alpha) * e1) >>> 16));
            next_value = sat16(64'(next_lp1) >>> 16);
          end
          PROC_LP2: begin
            // second stage follows the first stage's previous output
            next_lp1   = 32'(64'(lp1) + ((64'(alpha) * e1) >>> 16));
            next_lp2   = 32'(64'(lp2) + ((64'(alpha) * e2) >>> 16));
            next_value = sat16(64'(next_lp2) >>> 16);
          end
          default: next_value = 16'sh0000;       // off or reserved codes
        endcase
        next_hist = {hist[HIST_LEN-2:0], next_value};
      end
      if (cfg_wr.en) begin
        unique case (off)
          ADDR_CHAN_PROC: begin
            next_cfg.proc_select = cfg_wr.data[15:0];
            clr = (cfg_wr.data[PROC_LSB +: 3] != proc_mode) ||
                  (cfg_wr.data[CONN_LSB +: 3] !=
                   cfg.proc_select[CONN_LSB +: 3]);
          end
          ADDR_CHAN_LOWPASS: next_cfg.lowpass_hz = cfg_wr.data[15:0];
          ADDR_CHAN_MULT:    next_cfg.scale_mult = cfg_wr.data;
          ADDR_CHAN_ADD:     next_cfg.scale_add  = cfg_wr.data;
          ADDR_CHAN_FF0:     next_cfg.ff_coef0   = cfg_wr.data;
          ADDR_CHAN_FF1:     next_cfg.ff_coef1   = cfg_wr.data;
          ADDR_CHAN_FF2:     next_cfg.ff_coef2   = cfg_wr.data;
          ADDR_CHAN_FB1:     next_cfg.fb_coef1   = cfg_wr.data;
          ADDR_CHAN_FB2:     next_cfg.fb_coef2   = cfg_wr.data;
          default: ;
        endcase
      end
      // stale history would ring through a newly chosen filter
      if (clr) begin
        next_x1  = 16'sh0000;
        next_x2  = 16'sh0000;
        next_y1  = 16'sh0000;
        next_y2  = 16'sh0000;
        next_lp1 = 32'sh0000_0000;
        next_lp2 = 32'sh0000_0000;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        cfg             <= '0;
        cfg.proc_select <= RST_PROC_SELECT;
        cfg.lowpass_hz  <= RST_LOWPASS_HZ;
        cfg.scale_mult  <= RST_SCALE_MULT;
        x1              <= 16'sh0000;
        x2              <= 16'sh0000;
        y1              <= 16'sh0000;
        y2              <= 16'sh0000;
        lp1             <= 32'sh0000_0000;
        lp2             <= 32'sh0000_0000;
        value           <= 16'sh0000;
        hist            <= '0;
      end else begin
        cfg   <= next_cfg;
        x1    <= next_x1;
        x2    <= next_x2;
        y1    <= next_y1;
        y2    <= next_y2;
        lp1   <= next_lp1;
        lp2   <= next_lp2;
        value <= next_value;
        hist  <= next_hist;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // logical channels, evaluated on each logic tick

  for (genvar k = 0; k < N_LOGIC; k++) begin : g_logic
    assfc_logic_cfg_t   cfg, next_cfg;
    logic signed [31:0] value, next_value;
    logic signed [31:0] a, b, sum, prd, step;
    logic signed [63:0] ab;
    logic signed [32:0] p0, p1;
    logic [15:0]        off;
    logic [7:0]         sel;

    assign logic_value[k] = value;

    always_comb begin
      next_cfg   = cfg;
      next_value = value;
      off = cfg_wr.addr - 16'(LOGIC_STRIDE * k);
      p0  = $signed({1'b0, cfg.param0});
      p1  = $signed({1'b0, cfg.param1});
      // selectors: physical channels first, then logical from 8 up
      a = 32'sh0000_0000;
      b = 32'sh0000_0000;
      for (int i = 0; i < N_PHYS; i++) begin
        if (cfg.input_a == 8'(i)) a = 32'($signed(phys_value[i]));
        if (cfg.input_b == 8'(i)) b = 32'($signed(phys_value[i]));
      end
      for (int j = 0; j < N_LOGIC; j++) begin
        sel = SRC_LOGIC_BASE + 8'(j);
        if (cfg.input_a == sel) a = $signed(logic_value[j]);
        if (cfg.input_b == sel) b = $signed(logic_value[j]);
      end
      // display mode is addition with both selectors equal, p0 = 1, p1 = 0
      sum = sat32((66'(a) * 66'(p0) + 66'(b) * 66'(p1)) >>> 16);
      ab  = 64'(a) * 64'(b);
      prd = sat32(66'((66'(sat32(66'(ab >>> 16))) * 66'(p0)) >>> 16));
      step = 32'sh0000_0000;
      if (logic_tick) begin
        unique case (cfg.function_code)
          FN_ADD:  next_value = sum;
          FN_IADD: next_value = sat32(66'(value) + 66'(sum));
          FN_MUL:  next_value = prd;
          FN_IMUL: next_value = sat32(66'(value) + 66'(prd));
          FN_CMP:  next_value = (a > b) ? 32'sh0000_0001 : step;
          FN_HYST: begin
            if (33'(a) > p0) begin
              next_value = 32'sh0000_0001;
            end else if (33'(a) < p1) begin
              next_value = 32'sh0000_0000;
            end
          end
          default: next_value = 32'sh0000_0000;  // off or unknown code
        endcase
      end
      if (cfg_wr.en) begin
        unique case (off)
          ADDR_LOGIC_CODE: begin
            next_cfg.function_code = cfg_wr.data[15:0];
            if (cfg_wr.data[15:0] != cfg.function_code) begin
              next_value = 32'sh0000_0000;       // restart integrals
            end
          end
          ADDR_LOGIC_IN_A: next_cfg.input_a = cfg_wr.data[7:0];
          ADDR_LOGIC_IN_B: next_cfg.input_b = cfg_wr.data[7:0];
          ADDR_LOGIC_PAR0: next_cfg.param0  = cfg_wr.data;
          ADDR_LOGIC_PAR1: next_cfg.param1  = cfg_wr.data;
          default: ;
        endcase
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        cfg       <= '0;
        cfg.function_code <= (k < N_DISPLAY) ? FN_ADD : FN_OFF;
        cfg.input_a <= (k == 1) ? 8'h01 : 8'h00;
        cfg.input_b <= (k == 1) ? 8'h01 : 8'h00;
        cfg.param0  <= (k < 4) ? UNITY_Q16 : 32'h0000_0000;
        value     <= 32'sh0000_0000;
      end else begin
        cfg   <= next_cfg;
        value <= next_value;
      end
    end
  end

endmodule

// [sim/assfc_core_asserts.sv]
// assfc_core_asserts: port-level timing checks for assfc_core.
// assumes one clk_sys domain; bound onto every assfc_core instance.
module assfc_core_asserts
  import assfc_pkg::*;
#(
  parameter int unsigned HIST_LEN = HIST_DEPTH
) (
  input logic                                  clk_sys,
  input logic                                  reset_n,
  input logic                                  conv_valid,
  input logic                                  sample_tick,
  input logic                                  logic_tick,
  input logic                                  phys_valid,
  input logic                                  logic_valid,
  input logic [N_PHYS-1:0][15:0]               phys_value,
  input logic [N_PHYS-1:0][HIST_LEN-1:0][15:0] phys_hist
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // a period never drops below one microsecond (20 cycles)
  // nineteen quiet cycles, split to keep each repetition short
  sequence quiet_s;
    !sample_tick [*8] ##1 !sample_tick [*8] ##1 !sample_tick [*3];
  endsequence
  sequence took_s;
    conv_valid ##1 phys_valid;
  endsequence
  valid_follow_a: assert property (conv_valid |=> phys_valid)
    else $error("no phys_valid after conv_valid");
  valid_only_a: assert property (!conv_valid |=> !phys_valid)
    else $error("phys_valid without conv_valid");
  value_hold_a: assert property (!phys_valid |-> $stable(phys_value))
    else $error("phys_value moved between samples");
  tick_gap_a: assert property (sample_tick |=> quiet_s)
    else $error("sample ticks too close");
  logic_on_a: assert property (logic_tick |-> sample_tick)
    else $error("logic tick off a sample tick");
  logic_result_a: assert property (logic_tick |=> logic_valid)
    else $error("no logic_valid after logic tick");
  logic_only_a: assert property (!logic_tick |=> !logic_valid)
    else $error("stray logic_valid");
  hist_new_a: assert property (
    phys_valid |-> phys_hist[0][0] == phys_value[0]
      && phys_hist[1][0] == phys_value[1])
    else $error("newest history entry differs from value");
  hist_shift_a: assert property (
    took_s |-> phys_hist[0][1] == $past(phys_hist[0][0]))
    else $error("history did not shift");
endmodule

bind assfc_core assfc_core_asserts #(.HIST_LEN(HIST_LEN)) u_chk (
  .clk_sys, .reset_n, .conv_valid, .sample_tick, .logic_tick, .phys_valid,
  .logic_valid, .phys_value, .phys_hist);

// [sim/assfc_ctl_model.sv]
// assfc_ctl_model: configuration master writing whole device registers.
// assumes calls come from one bench thread, never two at once.
module assfc_ctl_model
  import assfc_pkg::*;
(
  input  logic      clk_sys,
  output assfc_wr_t cfg_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////
  // strobe idle from time zero
  initial begin
    cfg_wr = '0;
  end
  // one-cycle strobe; a gap cycle follows each write
  task automatic put(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cfg_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge clk_sys);
    cfg_wr.en <= 1'b0;
  endtask
  // connection code must match in both channels
  task automatic put_mode(input logic [15:0] m);
    put(ADDR_CHAN_PROC, {16'h0000, m});
    put(ADDR_CHAN_PROC + CHAN_STRIDE, {16'h0000, m});
  endtask
  // value display wants the same source in both selectors
  task automatic put_src(input int unsigned k, input logic [7:0] src);
    put(ADDR_LOGIC_IN_A + 16'(LOGIC_STRIDE * k), {24'h00_0000, src});
    put(ADDR_LOGIC_IN_B + 16'(LOGIC_STRIDE * k), {24'h00_0000, src});
  endtask
endmodule

// [sim/analog_sample_scale_filter_cfg_bench.sv]
// bench: directed checks of timing, scaling, modes and logical defaults.
// assumes assfc_core with its bound checker and the write model.
module analog_sample_scale_filter_cfg_bench
  import assfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk_sys, reset_n, conv_valid;
  logic                     sample_tick, logic_tick, phys_valid, logic_valid;
  logic [N_PHYS-1:0][15:0]  conv_data, phys_value;
  logic [N_LOGIC-1:0][31:0] logic_value;
  assfc_wr_t                cfg_wr;
  int                       fails, checks, n;
  assfc_core u_dut (.clk_sys, .reset_n, .cfg_wr, .conv_valid, .conv_data,
    .sample_tick, .logic_tick, .phys_valid, .logic_valid, .phys_value,
    .phys_hist(), .logic_value);
  assfc_ctl_model u_ctl (.clk_sys, .cfg_wr);
  ////////////////////////////////////////
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // cycles between two consecutive ticks of one kind
  task automatic gap(input bit lg);
    n = 0;
    @(posedge clk_sys iff (lg ? logic_tick : sample_tick));
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(lg ? logic_tick : sample_tick));
  endtask
  task automatic conv(input logic [15:0] a, b);
    @(posedge clk_sys);
    conv_valid <= 1'b1;
    conv_data <= {b, a};
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////
  task automatic t_timer();
    gap(0);
    check("period", n, 2000);
    gap(1);
    check("logic period", n, 4000);
    u_ctl.put(ADDR_LOGIC_DIV, 32'h0000_0001);
    u_ctl.put(ADDR_SAMPLE_PERIOD, 32'h0028_0000);
    gap(0);
    gap(0);
    check("short period", n, 800);
    gap(1);
    check("divider one", n, 800);
  endtask
  task automatic t_scale();
    conv(16'd100, 16'hfffb);
    check("unity ch1", phys_value[0], 16'd100);
    check("unity ch2", phys_value[1], 16'hfffb);
    u_ctl.put(ADDR_CHAN_ADD, 32'h0003_0000);
    u_ctl.put(ADDR_CHAN_MULT + CHAN_STRIDE, 32'h0002_0000);
    conv(16'd100, 16'd20000);
    check("offset", phys_value[0], 16'd103);
    check("saturate", phys_value[1], 16'h7fff);
  endtask
  task automatic t_mode();
    u_ctl.put_mode(16'h0107);
    conv(16'hfffb, 16'hfffb);
    check("current ch1", phys_value[0], 16'h0000);
    check("current ch2", phys_value[1], 16'h0000);
    u_ctl.put_mode(16'h0000);
    conv(16'd100, 16'd100);
    check("off", phys_value[0], 16'h0000);
    u_ctl.put_mode(16'h0100);
    // channel 2 as a half-and-half average of the last two inputs
    u_ctl.put(ADDR_CHAN_FF0 + CHAN_STRIDE, 32'h0000_8000);
    u_ctl.put(ADDR_CHAN_FF1 + CHAN_STRIDE, 32'h0000_8000);
    u_ctl.put(ADDR_CHAN_PROC + CHAN_STRIDE, 32'h0000_0200);
    conv(16'd100, 16'd100);
    check("iir first", phys_value[1], 16'd100);
    conv(16'd100, 16'd100);
    check("iir settled", phys_value[1], 16'd200);
    u_ctl.put(ADDR_CHAN_PROC + CHAN_STRIDE, 32'h0000_0100);
  endtask
  task automatic t_logic();
    conv(16'd100, 16'd100);
    // a tick taken during conv would still see the old values
    @(posedge clk_sys iff logic_tick);
    @(posedge clk_sys iff logic_valid);
    #1;
    check("display 1", logic_value[0], 32'd103);
    check("display 2", logic_value[1], 32'd200);
    check("off chan", logic_value[2], 32'd0);
    u_ctl.put_src(2, SRC_LOGIC_BASE);
    u_ctl.put(ADDR_LOGIC_CODE + 16'(2 * LOGIC_STRIDE), {16'h0000, FN_ADD});
    u_ctl.put(ADDR_LOGIC_IN_A + 16'(3 * LOGIC_STRIDE), 32'h0000_0001);
    u_ctl.put(ADDR_LOGIC_CODE + 16'(3 * LOGIC_STRIDE), {16'h0000, FN_CMP});
    @(posedge clk_sys iff logic_tick);
    @(posedge clk_sys iff logic_valid);
    #1;
    check("logic source", logic_value[2], 32'd103);
    check("comparator", logic_value[3], 32'd1);
  endtask
  // reset, then scenarios in order
  initial begin
    reset_n = 1'b0;
    conv_valid = 1'b0;
    conv_data = '0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_timer();
    t_scale();
    t_mode();
    t_logic();
    close_out();
  end
  // about 17600 cycles expected; generous margin
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    close_out();
  end
endmodule
